// File: hdl/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_PWR  = 8'h00;
	localparam logic [7:0] OFF_OSC  = 8'h04;
	localparam logic [7:0] OFF_REG  = 8'h08;
	localparam logic [7:0] OFF_GATE = 8'h0C;
	localparam logic [7:0] OFF_STAT = 8'h10;
	// field positions
	localparam int PWR_IDLE_BIT = 0;
	localparam int PWR_STOP_BIT = 1;
	localparam int OSC_SUSP_BIT = 0;
	localparam int OSC_DIV_LSB  = 1;
	localparam int OSC_SRC_BIT  = 3;
	localparam int REG_DEEP_BIT = 0;
	localparam int REG_5V_BIT   = 1;
	localparam int N_PERIPH     = 8;
	// reset values
	localparam logic [7:0] GATE_RST    = 8'hFF;
	localparam logic [1:0] DIV_SEL_RST = 2'h3;
	localparam logic       SRC_RST     = 1'b0;
	localparam logic       REG5V_RST   = 1'b1;
	localparam logic       DEEP_RST    = 1'b0;
	// oscillator path: fixed predivide, then 1/2/4/8
	localparam int         OSC_MHZ = 48;
	localparam logic [5:0] PRE_DIV = 6'h04;
	localparam logic [5:0] NO_DIV  = 6'h01;
	// power modes
	typedef enum logic [2:0] {
		M_NORMAL   = 3'b000,
		M_IDLE     = 3'b001,
		M_SUSPEND  = 3'b010,
		M_STOP     = 3'b011,
		M_SHUTDOWN = 3'b100
	} pmc_mode_t;
	typedef struct packed {
		logic       src_direct;
		logic [1:0] div_sel;
	} pmc_clk_cfg_t;
	typedef struct packed {
		logic core_clk_en;
		logic power_nets_on;
		logic pins_hold;
		logic reg5v_on;
	} pmc_pwr_t;
	localparam pmc_clk_cfg_t CLK_CFG_RST = '{SRC_RST, DIV_SEL_RST};
endpackage : pmc_pkg
`default_nettype wire

// File: hdl/pmc_power_mode_controller.sv
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pmc_power_mode_controller
	import pmc_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                irq_pending,
	input  wire logic                usb_activity,
	input  wire logic                rst_other_req,
	input  wire logic                rst_pin_req,
	input  wire logic                por_req,
	output pmc_pwr_t                 pwr,
	output pmc_clk_cfg_t             clk_cfg,
	output logic                     system_clock_tick,
	output logic      [N_PERIPH-1:0] periph_clk_en,
	output logic                     sys_reset_req
);
	pmc_mode_t             mode_q;
	pmc_mode_t             mode_d;
	pmc_clk_cfg_t          cfg_q;
	pmc_clk_cfg_t          cfg_d;
	logic                  deep_q;
	logic                  deep_d;
	logic                  r5v_q;
	logic                  r5v_d;
	logic [N_PERIPH-1:0]   gate_q;
	logic [N_PERIPH-1:0]   gate_d;
	logic                  rst_req_q;
	logic                  rst_req_d;
	logic [31:0]           rdata_q;
	logic [31:0]           rdata_d;
	logic [4:0]            cnt_q;
	logic [4:0]            cnt_d;
	logic                  tick_q;
	logic                  tick_d;
	logic [5:0]            div_total;
	logic [4:0]            div_lim;
	logic                  mapped;
	logic                  wr;
	logic                  wake;
	logic                  run;
	logic                  periph_run;

	// bus decode; the slave never waits
	assign mapped  = (paddr == OFF_PWR) || (paddr == OFF_OSC) || (paddr == OFF_REG)
		|| (paddr == OFF_GATE) || (paddr == OFF_STAT);
	assign wr      = psel && penable && pwrite && mapped;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata  = rdata_q;

	// mode and control register next state
	always_comb
	begin
		mode_d    = mode_q;
		cfg_d     = cfg_q;
		deep_d    = deep_q;
		r5v_d     = r5v_q;
		gate_d    = gate_q;
		rst_req_d = 1'b0;
		wake      = 1'b0;
		if (wr && paddr == OFF_OSC)
		begin
			cfg_d.div_sel    = pwdata[OSC_DIV_LSB +: 2];
			cfg_d.src_direct = pwdata[OSC_SRC_BIT];
		end
		if (wr && paddr == OFF_REG)
		begin
			deep_d = pwdata[REG_DEEP_BIT];
			r5v_d  = pwdata[REG_5V_BIT];
		end
		if (wr && paddr == OFF_GATE)
			gate_d = pwdata[N_PERIPH-1:0];
		case (mode_q)
			M_NORMAL:
			begin
				// stop outranks idle in the same write
				if (wr && paddr == OFF_PWR && pwdata[PWR_STOP_BIT])
					mode_d = deep_q ? M_SHUTDOWN : M_STOP;
				else if (wr && paddr == OFF_PWR && pwdata[PWR_IDLE_BIT])
					mode_d = M_IDLE;
				else if (wr && paddr == OFF_OSC && pwdata[OSC_SUSP_BIT] && cfg_q.src_direct)
					mode_d = M_SUSPEND;
			end
			M_IDLE:
				if (irq_pending)
					mode_d = M_NORMAL;
			M_SUSPEND:
				if (usb_activity)
					mode_d = M_NORMAL;
			M_STOP:
				wake = rst_other_req || rst_pin_req || por_req;
			M_SHUTDOWN:
				wake = rst_pin_req || por_req;
			default:
				mode_d = M_NORMAL;
		endcase
		// waking through a reset behaves like a full system reset
		if (wake)
		begin
			mode_d    = M_NORMAL;
			cfg_d     = CLK_CFG_RST;
			deep_d    = DEEP_RST;
			r5v_d     = REG5V_RST;
			gate_d    = GATE_RST;
			rst_req_d = 1'b1;
		end
	end

	// mode and control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_q    <= M_NORMAL;
			cfg_q     <= CLK_CFG_RST;
			deep_q    <= DEEP_RST;
			r5v_q     <= REG5V_RST;
			gate_q    <= GATE_RST;
			rst_req_q <= 1'b0;
		end
		else
		begin
			mode_q    <= mode_d;
			cfg_q     <= cfg_d;
			deep_q    <= deep_d;
			r5v_q     <= r5v_d;
			gate_q    <= gate_d;
			rst_req_q <= rst_req_d;
		end
	end

	// read data is latched in the setup cycle
	always_comb
	begin
		rdata_d = rdata_q;
		if (psel && !penable && !pwrite)
		begin
			rdata_d = 32'h0000_0000;
			case (paddr)
				OFF_PWR:
				begin
					rdata_d[PWR_IDLE_BIT] = (mode_q == M_IDLE);
					rdata_d[PWR_STOP_BIT] = (mode_q == M_STOP) || (mode_q == M_SHUTDOWN);
				end
				OFF_OSC:
				begin
					rdata_d[OSC_SUSP_BIT]      = (mode_q == M_SUSPEND);
					rdata_d[OSC_DIV_LSB +: 2]  = cfg_q.div_sel;
					rdata_d[OSC_SRC_BIT]       = cfg_q.src_direct;
				end
				OFF_REG:
				begin
					rdata_d[REG_DEEP_BIT] = deep_q;
					rdata_d[REG_5V_BIT]   = r5v_q;
				end
				OFF_GATE:
					rdata_d[N_PERIPH-1:0] = gate_q;
				OFF_STAT:
					rdata_d[2:0] = mode_q;
				default:
					rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= rdata_d;
	end

	// system clock enable divider: predivide unless direct, then 1/2/4/8
	assign div_total = (cfg_q.src_direct ? NO_DIV : PRE_DIV) << cfg_q.div_sel;
	assign div_lim   = 5'(div_total - NO_DIV);
	assign run       = (mode_q == M_NORMAL) || (mode_q == M_IDLE);
	assign periph_run = run;

	always_comb
	begin
		cnt_d  = 5'h00;
		tick_d = 1'b0;
		if (run)
		begin
			tick_d = (cnt_q == div_lim);
			cnt_d  = (cnt_q >= div_lim) ? 5'h00 : 5'(cnt_q + 5'h01);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q  <= 5'h00;
			tick_q <= 1'b0;
		end
		else
		begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	// mode- and register-driven outputs
	assign system_clock_tick       = tick_q;
	assign clk_cfg           = cfg_q;
	assign sys_reset_req     = rst_req_q;
	assign pwr.core_clk_en   = (mode_q == M_NORMAL);
	assign pwr.power_nets_on = (mode_q != M_STOP) && (mode_q != M_SHUTDOWN);
	assign pwr.pins_hold     = (mode_q == M_STOP) || (mode_q == M_SHUTDOWN);
	assign pwr.reg5v_on      = r5v_q;

	// per-peripheral clock gates
	genvar gi;
	generate
		for (gi = 0; gi < N_PERIPH; gi++)
		begin : g_gate
			assign periph_clk_en[gi] = gate_q[gi] && periph_run;
		end
	endgenerate

	chk_normal_clocks: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == M_NORMAL |-> pwr.core_clk_en && pwr.power_nets_on && periph_clk_en == gate_q)
		else $error("normal mode lost a clock");

	chk_idle_entry: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == M_NORMAL && wr && paddr == OFF_PWR && pwdata[PWR_IDLE_BIT] && !pwdata[PWR_STOP_BIT]
		|=> mode_q == M_IDLE && !pwr.core_clk_en && periph_clk_en == gate_q)
		else $error("idle entry wrong");

	chk_idle_wake: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == M_IDLE && irq_pending |=> pwr.core_clk_en)
		else $error("interrupt did not wake idle");

	chk_suspend_gate: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == M_NORMAL && !cfg_q.src_direct && !(wr && paddr == OFF_PWR) |=> mode_q != M_SUSPEND)
		else $error("suspend without fast oscillator");

	chk_suspend_wake: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == M_SUSPEND
		|=> !system_clock_tick && mode_q == ($past(usb_activity) ? M_NORMAL : M_SUSPEND))
		else $error("suspend wake wrong");

	chk_stop_power: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == M_STOP && rst_other_req |-> pwr.pins_hold && !pwr.power_nets_on ##1
		mode_q == M_NORMAL && sys_reset_req)
		else $error("stop mode power or wake wrong");

	chk_shutdown_entry: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == M_NORMAL && deep_q && wr && paddr == OFF_PWR && pwdata[PWR_STOP_BIT]
		|=> mode_q == M_SHUTDOWN && pwr.reg5v_on == $past(r5v_q))
		else $error("shutdown entry wrong");

	chk_shutdown_hold: assert property (@(posedge pclk) disable iff (!presetn)
		mode_q == M_SHUTDOWN && !rst_pin_req && !por_req |=> mode_q == M_SHUTDOWN && !sys_reset_req)
		else $error("shutdown left without pin or power-on");

	chk_reset_clock: assert property (@(posedge pclk) disable iff (!presetn)
		sys_reset_req |-> cfg_q == CLK_CFG_RST && div_lim == 5'h1F)
		else $error("default clock setting not restored");

	chk_div_period: assert property (@(posedge pclk) disable iff (!presetn)
		system_clock_tick && run && $stable(cfg_q) && cfg_q.src_direct && cfg_q.div_sel == 2'h1
		|=> !system_clock_tick ##1 (system_clock_tick || !$past(run) || $past(cfg_q) != $past(cfg_q, 2)))
		else $error("divide-by-two period wrong");

	chk_periph_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(periph_clk_en & ~gate_q) == 8'h00)
		else $error("gated peripheral still clocked");

	chk_wake_defaults: assert property (@(posedge pclk) disable iff (!presetn)
		sys_reset_req |-> mode_q == M_NORMAL && gate_q == GATE_RST && !deep_q)
		else $error("wake did not restore defaults");
endmodule : pmc_power_mode_controller
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
	import pmc_pkg::*;
;
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic [4:0]          wake;
	pmc_pwr_t            pwr;
	pmc_clk_cfg_t        clk_cfg;
	logic                system_clock_tick;
	logic [N_PERIPH-1:0] periph_clk_en;
	logic                sys_reset_req;
	logic [32:0]         exp_q[$];
	int                  miscompares;
	int                  tests_run;
	int                  cyc;
	int                  seed;
	int                  rst_seen;
	logic [7:0]          gate_v;

	pmc_power_mode_controller dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq_pending(wake[0]), .usb_activity(wake[1]), .rst_other_req(wake[2]),
		.rst_pin_req(wake[3]), .por_req(wake[4]), .pwr(pwr), .clk_cfg(clk_cfg),
		.system_clock_tick(system_clock_tick), .periph_clk_en(periph_clk_en), .sys_reset_req(sys_reset_req)
	);

	// free-running bus clock, 100 ns period
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic chk(input logic [32:0] seen, input logic [32:0] expv);
		tests_run++;
		if (seen !== expv)
		begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask : chk

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	// one apb transfer; reads leave {pslverr, prdata} expectation for the monitor
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] expv);
		if (!wr)
			exp_q.push_back(expv);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		apb(1'b0, a, 32'h0, {1'b0, d});
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr

	// one-cycle pulse on a wake or reset input
	task automatic pulse(input int i);
		wake[i] <= 1'b1;
		@(posedge pclk);
		wake[i] <= 1'b0;
		@(posedge pclk);
	endtask : pulse

	// third tick interval is clean of any divider change
	task automatic period(input int expv);
		int n;
		for (int j = 0; j < 3; j++)
		begin
			n = 0;
			do
			begin
				@(negedge pclk);
				n++;
			end
			while (system_clock_tick !== 1'b1 && n < 300);
		end
		chk(33'(n), 33'(expv));
		@(posedge pclk);
	endtask : period

	// monitor: settled read answers compared against the oldest note
	always @(negedge pclk)
	begin
		if (psel && penable && pready && !pwrite && exp_q.size() != 0)
			chk({pslverr, prdata}, exp_q.pop_front());
		// count reset requests raised when a power-off mode is left
		if (sys_reset_req === 1'b1)
			rst_seen++;
	end

	// hang guard
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			miscompares++;
			summarize();
		end
	end

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, wake} = '0;
		presetn = 1'b0;
		seed = 41;
		{miscompares, tests_run, cyc, rst_seen} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(33'({pwr, clk_cfg}), 33'({4'b1101, CLK_CFG_RST}));
		chk(33'(periph_clk_en), 33'(GATE_RST));
		rd(OFF_OSC, 32'h6);
		rd(OFF_REG, 32'h2);
		rd(OFF_GATE, 32'hFF);
		rd(OFF_PWR, 32'h0);
		wr(OFF_STAT, 32'h3);
		rd(OFF_STAT, 32'h0);
		apb(1'b0, 8'h14, 32'h0, 33'h100000000);
		period(32);
		// divider ladder, then the undivided source
		for (int k = 0; k < 4; k++)
		begin
			wr(OFF_OSC, 32'(k << 1));
			period(4 << k);
		end
		wr(OFF_OSC, 32'h8);
		period(1);
		wr(OFF_OSC, 32'hA);
		period(2);
		gate_v = 8'($random(seed));
		wr(OFF_GATE, {24'h0, gate_v});
		rd(OFF_GATE, {24'h0, gate_v});
		chk(33'(periph_clk_en), 33'(gate_v));
		// core halt, peripherals still clocked, interrupt wakes
		wr(OFF_PWR, 32'h1);
		rd(OFF_STAT, 32'h1);
		chk(33'({pwr.core_clk_en, periph_clk_en}), 33'({1'b0, gate_v}));
		pulse(0);
		rd(OFF_STAT, 32'h0);
		chk(33'(pwr.core_clk_en), 33'h1);
		// clock halt with direct source, usb wakes
		wr(OFF_OSC, 32'h9);
		rd(OFF_STAT, 32'h2);
		chk(33'({pwr.core_clk_en, periph_clk_en}), 33'h0);
		pulse(1);
		rd(OFF_STAT, 32'h0);
		// clock halt refused without the direct source
		wr(OFF_OSC, 32'h6);
		wr(OFF_OSC, 32'h7);
		rd(OFF_STAT, 32'h0);
		// power-off: interrupt ignored, other reset wakes to defaults
		wr(OFF_PWR, 32'h2);
		rd(OFF_STAT, 32'h3);
		chk(33'({pwr.power_nets_on, pwr.pins_hold}), 33'h1);
		pulse(0);
		rd(OFF_STAT, 32'h3);
		pulse(2);
		rd(OFF_STAT, 32'h0);
		rd(OFF_GATE, 32'hFF);
		rd(OFF_OSC, 32'h6);
		chk(33'(rst_seen), 33'h1);
		// deep power-down: only pin and power-on wake, regulator kept as set
		for (int k = 3; k < 5; k++)
		begin
			wr(OFF_REG, (k == 3) ? 32'h3 : 32'h1);
			wr(OFF_PWR, 32'h2);
			rd(OFF_STAT, 32'h4);
			chk(33'({pwr.power_nets_on, pwr.pins_hold, pwr.reg5v_on}), 33'({2'b01, k == 3}));
			pulse(2);
			pulse(0);
			pulse(1);
			rd(OFF_STAT, 32'h4);
			pulse(k);
			rd(OFF_STAT, 32'h0);
			rd(OFF_REG, 32'h2);
		end
		chk(33'(rst_seen), 33'h3);
		summarize();
	end
endmodule : tb
`default_nettype wire
